/* hdl/bce_pkg.sv */
// constants for the branch condition evaluator and trap sequencer
// assumes a single processor clock; opcode and flags come from the execute stage
package bce_pkg;
  localparam logic [7:0] TRAP_OPCODE  = 8'hF2;
  localparam int         SEL_HI       = 7;
  localparam int         SEL_LO       = 4;
  localparam logic [3:0] COND_NEVER   = 4'h0;
  localparam logic [3:0] COND_LT      = 4'h1;
  localparam logic [3:0] COND_LE      = 4'h2;
  localparam logic [3:0] COND_ULE     = 4'h3;
  localparam logic [3:0] COND_OV      = 4'h4;
  localparam logic [3:0] COND_MI      = 4'h5;
  localparam logic [3:0] COND_ZE      = 4'h6;
  localparam logic [3:0] COND_CY      = 4'h7;
  localparam logic [3:0] COND_ALWAYS  = 4'h8;
  localparam logic [3:0] COND_GE      = 4'h9;
  localparam logic [3:0] COND_GT      = 4'hA;
  localparam logic [3:0] COND_UGT     = 4'hB;
  localparam logic [3:0] COND_NOV     = 4'hC;
  localparam logic [3:0] COND_PL      = 4'hD;
  localparam logic [3:0] COND_NZ      = 4'hE;
  localparam logic [3:0] COND_NC      = 4'hF;
  localparam logic [3:0] TRAP_EXEC_CYCLES = 4'h6;
  localparam logic [11:0] SP_DEC_PC   = 12'h002;
  localparam logic [11:0] SP_DEC_FL   = 12'h001;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [11:0] SP_RESET    = 12'h000;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [15:0] ADDR_RESET  = 16'h0000;

  typedef enum logic [5:0] {
    BCE_IDLE  = 6'h01,
    BCE_PUSHL = 6'h02,
    BCE_PUSHH = 6'h04,
    BCE_PUSHF = 6'h08,
    BCE_VECH  = 6'h10,
    BCE_VECL  = 6'h20
  } bce_state_t;
endpackage

/* hdl/bce_cond.sv */
// combinational flag test for one condition selector
// flags arrive already current for the executing cycle
`timescale 1ns/1ps
module bce_cond
(
  input  wire logic [3:0] sel,
  input  wire logic       c,
  input  wire logic       z,
  input  wire logic       s,
  input  wire logic       v,
  output logic            hit
);
  logic lt;
  logic le;
  logic base;
  always_comb
  begin
    lt = s ^ v;
    le = z | lt;
    // low three bits pick the test, bit 3 inverts it
    case (sel[2:0])
      3'h0:    base = 1'b0;
      3'h1:    base = lt;
      3'h2:    base = le;
      3'h3:    base = c | z;
      3'h4:    base = v;
      3'h5:    base = s;
      3'h6:    base = z;
      3'h7:    base = c;
      default: base = 1'b0;
    endcase
    hit = base ^ sel[3];
  end
endmodule

/* hdl/bce_top.sv */
// branch decision, relative target and trap stack/vector sequencer
// execute stage presents one instruction per exec_valid pulse; memory writes
// and vector reads always complete in the cycle they are issued
`timescale 1ns/1ps
module bce_top
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        exec_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic        is_cond_jump,
  input  wire logic        is_relative,
  input  wire logic [15:0] abs_target,
  input  wire logic [7:0]  relative_displacement,
  input  wire logic [15:0] next_pc,
  input  wire logic [7:0]  trap_vector,
  input  wire logic        flag_c,
  input  wire logic        flag_z,
  input  wire logic        flag_s,
  input  wire logic        flag_v,
  input  wire logic [7:0]  flags_byte,
  input  wire logic [11:0] sp_in,
  input  wire logic [7:0]  mem_rdata,
  output logic             pc_load,
  output logic [15:0]      pc_value,
  output logic             jump_taken,
  output logic             mem_we,
  output logic             mem_re,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic             sp_load,
  output logic [11:0]      sp_value,
  output logic             trap_busy
);
  bce_pkg::bce_state_t state;
  bce_pkg::bce_state_t next_state;
  logic [15:0] pc_save;
  logic [15:0] next_pc_save;
  logic [11:0] sp_work;
  logic [11:0] next_sp_work;
  logic [7:0]  fl_save;
  logic [7:0]  next_fl_save;
  logic [7:0]  vec;
  logic [7:0]  next_vec;
  logic [7:0]  vec_hi;
  logic [7:0]  next_vec_hi;
  logic        next_pc_load;
  logic [15:0] next_pc_value;
  logic        next_jump_taken;
  logic        next_mem_we;
  logic        next_mem_re;
  logic [15:0] next_mem_addr;
  logic [7:0]  next_mem_wdata;
  logic        next_sp_load;
  logic [11:0] next_sp_value;
  logic        next_trap_busy;
  logic        cond_hit;
  logic [15:0] rel_target;

  // selector read live from the opcode, flags live from the stage
  bce_cond u_cond
  (
    .sel (opcode[bce_pkg::SEL_HI:bce_pkg::SEL_LO]),
    .c   (flag_c),
    .z   (flag_z),
    .s   (flag_s),
    .v   (flag_v),
    .hit (cond_hit)
  );

  assign rel_target = next_pc + {{8{relative_displacement[7]}}, relative_displacement};

  always_comb
  begin
    next_state      = state;
    next_pc_save    = pc_save;
    next_sp_work    = sp_work;
    next_fl_save    = fl_save;
    next_vec        = vec;
    next_vec_hi     = vec_hi;
    next_pc_load    = 1'b0;
    next_pc_value   = pc_value;
    next_jump_taken = 1'b0;
    next_mem_we     = 1'b0;
    next_mem_re     = 1'b0;
    next_mem_addr   = mem_addr;
    next_mem_wdata  = mem_wdata;
    next_sp_load    = 1'b0;
    next_sp_value   = sp_value;
    next_trap_busy  = 1'b0;
    case (state)
      bce_pkg::BCE_IDLE:
      begin
        if (exec_valid && opcode == bce_pkg::TRAP_OPCODE)
        begin
          // trap: drop SP by 2, low byte of PC goes to the higher address
          next_sp_work   = sp_in - bce_pkg::SP_DEC_PC;
          next_pc_save   = next_pc;
          next_fl_save   = flags_byte;
          next_vec       = trap_vector;
          next_mem_we    = 1'b1;
          next_mem_addr  = {4'h0, sp_in - bce_pkg::SP_DEC_PC + 12'h001};
          next_mem_wdata = next_pc[7:0];
          next_trap_busy = 1'b1;
          next_state     = bce_pkg::BCE_PUSHL;
        end
        else if (exec_valid && is_cond_jump)
        begin
          // not taken leaves the PC on the sequential path
          if (cond_hit)
          begin
            next_pc_load    = 1'b1;
            next_jump_taken = 1'b1;
            next_pc_value   = is_relative ? rel_target : abs_target;
          end
        end
      end
      bce_pkg::BCE_PUSHL:
      begin
        next_mem_we    = 1'b1;
        next_mem_addr  = {4'h0, sp_work};
        next_mem_wdata = pc_save[15:8];
        next_trap_busy = 1'b1;
        next_state     = bce_pkg::BCE_PUSHH;
      end
      bce_pkg::BCE_PUSHH:
      begin
        next_sp_work   = sp_work - bce_pkg::SP_DEC_FL;
        next_mem_we    = 1'b1;
        next_mem_addr  = {4'h0, sp_work - bce_pkg::SP_DEC_FL};
        next_mem_wdata = fl_save;
        next_trap_busy = 1'b1;
        next_state     = bce_pkg::BCE_PUSHF;
      end
      bce_pkg::BCE_PUSHF:
      begin
        next_sp_load   = 1'b1;
        next_sp_value  = sp_work;
        next_mem_re    = 1'b1;
        next_mem_addr  = {8'h00, vec};
        next_trap_busy = 1'b1;
        next_state     = bce_pkg::BCE_VECH;
      end
      bce_pkg::BCE_VECH:
      begin
        next_vec_hi    = mem_rdata;
        next_mem_re    = 1'b1;
        next_mem_addr  = {8'h00, vec + 8'h01};
        next_trap_busy = 1'b1;
        next_state     = bce_pkg::BCE_VECL;
      end
      bce_pkg::BCE_VECL:
      begin
        // sixth execute cycle: PC taken from the vector word
        next_pc_load  = 1'b1;
        next_pc_value = {vec_hi, mem_rdata};
        next_state    = bce_pkg::BCE_IDLE;
      end
      default:
      begin
        next_state = bce_pkg::BCE_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state      <= bce_pkg::BCE_IDLE;
      pc_save    <= bce_pkg::PC_RESET;
      sp_work    <= bce_pkg::SP_RESET;
      fl_save    <= bce_pkg::BYTE_RESET;
      vec        <= bce_pkg::BYTE_RESET;
      vec_hi     <= bce_pkg::BYTE_RESET;
      pc_load    <= 1'b0;
      pc_value   <= bce_pkg::PC_RESET;
      jump_taken <= 1'b0;
      mem_we     <= 1'b0;
      mem_re     <= 1'b0;
      mem_addr   <= bce_pkg::ADDR_RESET;
      mem_wdata  <= bce_pkg::BYTE_RESET;
      sp_load    <= 1'b0;
      sp_value   <= bce_pkg::SP_RESET;
      trap_busy  <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      pc_save    <= next_pc_save;
      sp_work    <= next_sp_work;
      fl_save    <= next_fl_save;
      vec        <= next_vec;
      vec_hi     <= next_vec_hi;
      pc_load    <= next_pc_load;
      pc_value   <= next_pc_value;
      jump_taken <= next_jump_taken;
      mem_we     <= next_mem_we;
      mem_re     <= next_mem_re;
      mem_addr   <= next_mem_addr;
      mem_wdata  <= next_mem_wdata;
      sp_load    <= next_sp_load;
      sp_value   <= next_sp_value;
      trap_busy  <= next_trap_busy;
    end
  end

  sequence s_trap_start;
    state == bce_pkg::BCE_IDLE && exec_valid && opcode == bce_pkg::TRAP_OPCODE;
  endsequence

  sequence s_trap_pushes;
    mem_we [*3] ##1 (sp_load && !mem_we);
  endsequence

  chk_never_taken: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state == bce_pkg::BCE_IDLE && exec_valid && is_cond_jump
      && opcode[7:4] == bce_pkg::COND_NEVER && opcode != bce_pkg::TRAP_OPCODE
      |=> !jump_taken)
    else $error("never code took a jump");

  chk_always_taken: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state == bce_pkg::BCE_IDLE && exec_valid && is_cond_jump
      && opcode[7:4] == bce_pkg::COND_ALWAYS |=> jump_taken && pc_load)
    else $error("always code did not jump");

  chk_signed_lt: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state == bce_pkg::BCE_IDLE && exec_valid && is_cond_jump
      && opcode[7:4] == bce_pkg::COND_LT |=> jump_taken == $past(flag_s ^ flag_v))
    else $error("less-than decision wrong");

  chk_unsigned_gt: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state == bce_pkg::BCE_IDLE && exec_valid && is_cond_jump
      && opcode[7:4] == bce_pkg::COND_UGT
      |=> jump_taken == $past(!flag_c && !flag_z))
    else $error("unsigned greater decision wrong");

  chk_carry_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state == bce_pkg::BCE_IDLE && exec_valid && is_cond_jump
      && opcode[7:4] == bce_pkg::COND_NC && opcode != bce_pkg::TRAP_OPCODE
      |=> jump_taken == $past(!flag_c))
    else $error("no-carry decision wrong");

  chk_rel_target: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state == bce_pkg::BCE_IDLE && exec_valid && is_cond_jump && is_relative
      && opcode != bce_pkg::TRAP_OPCODE && cond_hit
      |=> pc_value == $past(next_pc) + {{8{$past(relative_displacement[7])}},
                                        $past(relative_displacement)})
    else $error("relative target wrong");

  chk_no_jump_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state == bce_pkg::BCE_IDLE && !(exec_valid && is_cond_jump) |=> !jump_taken)
    else $error("jump without a conditional jump");

  chk_trap_seq: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_trap_start |=> s_trap_pushes ##2 pc_load)
    else $error("trap sequence out of order");

  chk_trap_sp: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_trap_start |-> ##4 sp_value == $past(sp_in, 4) - 12'h003)
    else $error("trap stack pointer wrong");
endmodule

/* tb/bce_mem_model.sv */
// memory side model for the trap sequencer: byte store and vector source
// assumes at most one read or write per clock and combinational read data
`timescale 1ns/1ps
module bce_mem_model
(
  input  wire logic        ref_clk,
  input  wire logic        mem_we,
  input  wire logic        mem_re,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [0:255];
  logic [7:0] idle_pat = 8'hA5;

  initial
  begin
    for (int a = 0; a < 256; a++)
      mem[a] = 8'(a) ^ 8'h5A;
  end

  always @(posedge ref_clk)
  begin
    idle_pat <= ~idle_pat;
    if (mem_we)
      mem[mem_addr[7:0]] <= mem_wdata;
  end

  // no read in progress: a changing pattern, never a stale byte
  assign mem_rdata = mem_re ? mem[mem_addr[7:0]] : idle_pat;
endmodule

/* tb/branch_condition_eval_bench.sv */
// self-checking bench for the branch decision and trap sequencer
// assumes a one-cycle jump answer and a six-cycle trap walk
`timescale 1ns/1ps
module branch_condition_eval_bench;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        exec_valid = 1'b0, is_cond_jump = 1'b0, is_relative = 1'b0;
  logic [7:0]  opcode = 8'h00, relative_displacement = 8'h00, trap_vector = 8'h00;
  logic [7:0]  flags_byte = 8'h00;
  logic [15:0] abs_target = 16'h0000, next_pc = 16'h0000;
  logic        flag_c = 1'b0, flag_z = 1'b0, flag_s = 1'b0, flag_v = 1'b0;
  logic [11:0] sp_in = 12'h000;
  logic [7:0]  mem_rdata, mem_wdata;
  logic        pc_load, jump_taken, mem_we, mem_re, sp_load, trap_busy;
  logic [15:0] pc_value, mem_addr;
  logic [11:0] sp_value;
  int          mismatches = 0;
  int          checks = 0;

  always #5 ref_clk = ~ref_clk;

  bce_top u_dut (.ref_clk, .rst_b, .exec_valid, .opcode, .is_cond_jump, .is_relative,
    .abs_target, .relative_displacement, .next_pc, .trap_vector, .flag_c, .flag_z,
    .flag_s, .flag_v, .flags_byte, .sp_in, .mem_rdata, .pc_load, .pc_value,
    .jump_taken, .mem_we, .mem_re, .mem_addr, .mem_wdata, .sp_load, .sp_value,
    .trap_busy);

  bce_mem_model u_mem (.ref_clk, .mem_we, .mem_re, .mem_addr, .mem_wdata, .mem_rdata);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic cond_true(input logic [3:0] sel, input logic [3:0] f);
    logic c, z, s, v, r;
    {c, z, s, v} = f;
    case (sel[2:0])
      3'h0: r = 1'b0;
      3'h1: r = s ^ v;
      3'h2: r = z | (s ^ v);
      3'h3: r = c | z;
      3'h4: r = v;
      3'h5: r = s;
      3'h6: r = z;
      default: r = c;
    endcase
    return r ^ sel[3];
  endfunction

  // back-to-back jumps, every selector against every flag set, flags new each cycle
  task automatic jump_seq(input logic rel);
    logic        exp_t [$];
    logic [15:0] exp_pc [$];
    logic [3:0]  f;
    logic        t;
    logic [15:0] p;
    for (int i = 0; i < 257; i++)
    begin
      @(negedge ref_clk);
      if (i >= 1)
      begin
        t = exp_t.pop_front();
        p = exp_pc.pop_front();
        check("jump_taken", 32'(jump_taken), 32'(t));
        check("pc_load", 32'(pc_load), 32'(t));
        if (t)
          check("pc_value", 32'(pc_value), 32'(p));
      end
      exec_valid = (i < 256);
      f = i[7:4] ^ i[3:0];
      {flag_c, flag_z, flag_s, flag_v} = f;
      opcode = {i[3:0], rel ? 4'hB : 4'hD};
      is_cond_jump = 1'b1;
      is_relative = rel;
      relative_displacement = i[7:0];
      next_pc = {i[7:0], ~i[7:0]};
      abs_target = ~next_pc;
      if (i < 256)
      begin
        exp_t.push_back(cond_true(i[3:0], f));
        exp_pc.push_back(rel ? next_pc + {{8{i[7]}}, i[7:0]} : abs_target);
      end
    end
    $display("jump test relative=%0d done", rel);
  endtask

  // trap with an always-true jump held on the bus that must be ignored
  task automatic trap_seq();
    logic [5:0]  ev [6] = '{6'h21, 6'h21, 6'h21, 6'h19, 6'h11, 6'h04};
    logic [15:0] ea [5] = '{16'h00FF, 16'h00FE, 16'h00FD, 16'h0040, 16'h0041};
    logic [7:0]  ed [3] = '{8'hCD, 8'hAB, 8'h5E};
    @(negedge ref_clk);
    sp_in = 12'h100;
    next_pc = 16'hABCD;
    flags_byte = 8'h5E;
    trap_vector = 8'h40;
    opcode = 8'hF2;
    is_cond_jump = 1'b0;
    exec_valid = 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      @(negedge ref_clk);
      check("trap strobes", 32'({mem_we, mem_re, sp_load, pc_load, jump_taken, trap_busy}),
            32'(ev[k]));
      if (k < 5)
        check("mem_addr", 32'(mem_addr), 32'(ea[k]));
      if (k < 3)
        check("mem_wdata", 32'(mem_wdata), 32'(ed[k]));
      if (k == 3)
        check("sp_value", 32'(sp_value), 32'h0FD);
      if (k == 0)
      begin
        opcode = 8'h8D;
        is_cond_jump = 1'b1;
      end
      if (k == 5)
        exec_valid = 1'b0;
      if (k == 5)
        check("trap pc_value", 32'(pc_value), 32'h1A1B);
    end
    $display("trap test done");
  endtask

  // reset dropped in mid trap, then a jump on the first edge after release
  task automatic reset_mid();
    @(negedge ref_clk);
    sp_in = 12'h080;
    opcode = 8'hF2;
    is_cond_jump = 1'b0;
    exec_valid = 1'b1;
    @(negedge ref_clk);
    exec_valid = 1'b0;
    @(negedge ref_clk);
    check("trap running", 32'(trap_busy), 32'h1);
    rst_b = 1'b0;
    @(negedge ref_clk);
    check("mid reset outputs", 32'({pc_load, jump_taken, mem_we, mem_re, sp_load, trap_busy}),
          32'h0);
    rst_b = 1'b1;
    opcode = 8'h8D;
    is_cond_jump = 1'b1;
    is_relative = 1'b0;
    abs_target = 16'h1234;
    exec_valid = 1'b1;
    @(negedge ref_clk);
    exec_valid = 1'b0;
    check("jump after reset", 32'({jump_taken, pc_value}), 32'h11234);
    $display("mid reset test done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge ref_clk);
    check("reset outputs", 32'({pc_load, jump_taken, mem_we, mem_re, sp_load, trap_busy}), 0);
    @(negedge ref_clk);
    rst_b = 1'b1;
    jump_seq(1'b0);
    jump_seq(1'b1);
    trap_seq();
    jump_seq(1'b1);
    reset_mid();
    give_verdict();
  end

  // whole run needs about 800 cycles; allow over six times that
  initial
  begin
    #(5000 * 10);
    mismatches++;
    give_verdict();
  end
endmodule
